// file: design/clk_sel_pkg.sv
package clk_sel_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  MODE_CFG_ADDR     = 8'h01;
  localparam logic [7:0]  PLL_CFG_ADDR      = 8'h04;
  localparam logic [31:0] MODE_CFG_RESET    = 32'h0000_0000;
  localparam logic [31:0] PLL_CFG_RESET     = 32'h000f_03ff;

  // ==========================================================
  // Field positions
  localparam int          INTERP_LSB        = 6;
  localparam int          SINGLE_PORT_BIT   = 0;
  localparam int          PLL_EN_BIT        = 15;
  localparam int          VCO_DIV_LSB       = 13;
  localparam int          MULT_LSB          = 11;
  localparam int          BAND_LSB          = 2;
  localparam int          LOCK_BIT          = 21;
  localparam logic [5:0]  BAND_AUTO         = 6'h3f;
  localparam logic [5:0]  AUTO_BAND_DEFAULT = 6'h1f;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          LOCK_TIME_NS      = 5000000;
  localparam int          LOCK_CYCLES       = LOCK_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       enable;
    logic [1:0] vco_divider_ratio;
    logic [1:0] sample_clock_multiplier_ratio;
    logic [5:0] band;
  } pll_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef enum logic [2:0] {
    ST_BYPASS  = 3'b001,
    ST_LOCKING = 3'b010,
    ST_LOCKED  = 3'b100
  } pll_state_e;

  // Two-bit ratio codes map to 1, 2, 4, 8
  function automatic logic [3:0] ratio_of(input logic [1:0] code);
    ratio_of = 4'h1 << code;
  endfunction : ratio_of

endpackage : clk_sel_pkg

// file: design/dac_sample_clock_select_multiplier.sv
`timescale 1ns/1ps
module dac_sample_clock_select_multiplier
  import clk_sel_pkg::*;
#(
  parameter int         LOCK_WAIT = clk_sel_pkg::LOCK_CYCLES,
  parameter logic [5:0] AUTO_BAND = clk_sel_pkg::AUTO_BAND_DEFAULT
) (
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_reference_clock_input,
  input  wire clk_sel_pkg::reg_req_s i_reg_req,
  output logic [31:0]             o_reg_rdata,
  output logic                    o_reg_rvalid,
  output logic                    o_converter_sample_clock,
  output logic                    o_vco_tick,
  output logic                    o_data_rate_clock_output,
  output logic                    o_pll_lock
);
  import clk_sel_pkg::*;

  // ==========================================================
  // Reference input synchroniser and edge detect
  logic ref_meta_q;
  logic ref_sync_q;
  logic ref_prev_q;
  wire  ref_rise = ref_sync_q & ~ref_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_meta_q <= i_reference_clock_input;
      ref_sync_q <= ref_meta_q;
      ref_prev_q <= ref_sync_q;
    end
  end

  // ==========================================================
  // Registers
  logic [31:0] mode_q;
  logic [31:0] pll_q;
  pll_cfg_s    cfg;
  pll_state_e  state_q;
  logic        band_done;

  assign cfg.enable                        = pll_q[PLL_EN_BIT];
  assign cfg.vco_divider_ratio             = pll_q[VCO_DIV_LSB +: 2];
  assign cfg.sample_clock_multiplier_ratio = pll_q[MULT_LSB +: 2];
  assign cfg.band                          = pll_q[BAND_LSB +: 6];

  wire wr_mode = i_reg_req.wr & (i_reg_req.addr == MODE_CFG_ADDR);
  wire wr_pll  = i_reg_req.wr & (i_reg_req.addr == PLL_CFG_ADDR);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_q <= MODE_CFG_RESET;
      pll_q  <= PLL_CFG_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= i_reg_req.wdata;
      end
      // Software write wins; auto result only lands when no write races it
      if (wr_pll) begin
        pll_q <= {11'h000, i_reg_req.wdata[20:0]};
      end else if (band_done) begin
        pll_q[BAND_LSB +: 6] <= AUTO_BAND;
      end
    end
  end

  wire [31:0] pll_read = {pll_q[31:22], state_q == ST_LOCKED, pll_q[20:0]};
  wire [31:0] rd_mux   = (i_reg_req.addr == MODE_CFG_ADDR) ? mode_q :
                         (i_reg_req.addr == PLL_CFG_ADDR)  ? pll_read : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata  <= 32'h0000_0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_req.rd;
      if (i_reg_req.rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Lock sequencing
  logic [31:0] lock_cnt_q;
  logic        auto_q;
  wire         lock_time_up = (lock_cnt_q >= 32'(LOCK_WAIT - 1));

  assign band_done = (state_q == ST_LOCKING) & lock_time_up & auto_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q    <= ST_BYPASS;
      lock_cnt_q <= 32'h0000_0000;
      auto_q     <= 1'b0;
    end else if (wr_pll) begin
      // Any reprogramming restarts acquisition if the enable bit is set, else returns to bypass
      state_q    <= i_reg_req.wdata[PLL_EN_BIT] ? ST_LOCKING : ST_BYPASS;
      lock_cnt_q <= 32'h0000_0000;
      auto_q     <= (i_reg_req.wdata[BAND_LSB +: 6] == BAND_AUTO);
    end else begin
      unique case (state_q)
        ST_BYPASS: begin
          state_q <= cfg.enable ? ST_LOCKING : ST_BYPASS;
        end
        ST_LOCKING: begin
          lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
          if (lock_time_up) begin
            state_q <= ST_LOCKED;
            auto_q  <= 1'b0;
          end
        end
        ST_LOCKED: begin
          state_q <= ST_LOCKED;
        end
      endcase
    end
  end

  assign o_pll_lock = (state_q == ST_LOCKED);

  // ==========================================================
  // Oscillator model: a rate accumulator against the measured reference period.
  // Limitation: at most one tick per i_clk, so the product is capped by the period.
  logic [31:0] period_cnt_q;
  logic [31:0] period_q;
  logic [31:0] acc_q;
  logic        vco_q;
  wire  [7:0]  vco_mult = 8'(ratio_of(cfg.vco_divider_ratio)) *
                          8'(ratio_of(cfg.sample_clock_multiplier_ratio));
  wire  [31:0] acc_sum  = acc_q + {24'h000000, vco_mult};
  wire         vco_fire = cfg.enable & (period_q != 32'h0000_0000) & (acc_sum >= period_q);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      period_cnt_q <= 32'h0000_0000;
      period_q     <= 32'h0000_0000;
      acc_q        <= 32'h0000_0000;
      vco_q        <= 1'b0;
    end else begin
      vco_q <= vco_fire;
      if (ref_rise) begin
        period_q     <= period_cnt_q + 32'h0000_0001;
        period_cnt_q <= 32'h0000_0000;
        acc_q        <= 32'h0000_0000;
      end else begin
        period_cnt_q <= period_cnt_q + 32'h0000_0001;
        acc_q        <= vco_fire ? (acc_sum - period_q) : acc_sum;
      end
    end
  end

  assign o_vco_tick = vco_q;

  // ==========================================================
  // Sample clock selection
  logic [3:0] n1_cnt_q;
  logic       sample_q;
  wire        n1_wrap     = (n1_cnt_q == ratio_of(cfg.vco_divider_ratio) - 4'h1);
  wire        sample_fire = cfg.enable ? (vco_q & n1_wrap) : ref_rise;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      n1_cnt_q <= 4'h0;
      sample_q <= 1'b0;
    end else begin
      sample_q <= sample_fire;
      if (vco_q) begin
        n1_cnt_q <= n1_wrap ? 4'h0 : n1_cnt_q + 4'h1;
      end
    end
  end

  assign o_converter_sample_clock = sample_q;

  // ==========================================================
  // Data-rate clock divider
  logic [3:0] dr_cnt_q;
  logic       data_q;
  wire  [3:0] interp   = ratio_of(mode_q[INTERP_LSB +: 2]);
  // Single-port halves the divisor; a divisor below one is held at one
  wire  [3:0] half     = (interp > 4'h1) ? (interp >> 1) : 4'h1;
  wire  [3:0] divisor  = mode_q[SINGLE_PORT_BIT] ? half : interp;
  wire        dr_wrap  = (dr_cnt_q >= divisor - 4'h1);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dr_cnt_q <= 4'h0;
      data_q   <= 1'b0;
    end else begin
      data_q <= sample_q & dr_wrap;
      if (sample_q) begin
        dr_cnt_q <= dr_wrap ? 4'h0 : dr_cnt_q + 4'h1;
      end
    end
  end

  assign o_data_rate_clock_output = data_q;

endmodule : dac_sample_clock_select_multiplier

// file: tb/ref_clock_source.sv
`timescale 1ns/1ps
// ====
// Reference source: toggles every HALF cycles, stands low while stopped
module ref_clock_source #(
  parameter int HALF = 12
) (
  input  wire logic i_clk,
  input  wire logic i_run,
  output logic      o_ref
);
  int cnt_q = 0;
  initial o_ref = 1'b0;
  always @(posedge i_clk) begin
    cnt_q <= (!i_run || cnt_q == HALF - 1) ? 0 : cnt_q + 1;
    o_ref <= i_run && (cnt_q == HALF - 1 ? !o_ref : o_ref);
  end
endmodule : ref_clock_source

// file: tb/dac_sample_clock_select_multiplier_props.sv
`timescale 1ns/1ps
module dac_sample_clock_select_multiplier_props
  import clk_sel_pkg::*;
#(
  parameter int LOCK_WAIT = 20
) (
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire logic                  i_reference_clock_input,
  input wire clk_sel_pkg::reg_req_s i_reg_req,
  input wire logic [31:0]           o_reg_rdata,
  input wire logic                  o_reg_rvalid,
  input wire logic                  o_converter_sample_clock,
  input wire logic                  o_vco_tick,
  input wire logic                  o_data_rate_clock_output,
  input wire logic                  o_pll_lock
);
  // ====
  // Shadows of the write port; the first data pulse after a mode write is skipped
  logic       en_q, single_q, ok_q;
  logic [1:0] if_q;
  logic [3:0] cnt_q;
  int         wait_q;
  wire        pll_wr = i_reg_req.wr && i_reg_req.addr == PLL_CFG_ADDR;
  wire        mode_wr = i_reg_req.wr && i_reg_req.addr == MODE_CFG_ADDR;
  wire        samp = o_converter_sample_clock;
  wire        dat = o_data_rate_clock_output;
  wire [3:0]  div = ((4'h1 << if_q) >> single_q) | 4'(if_q == 2'h0);
  always_ff @(posedge i_clk) en_q <= !i_reset && (pll_wr ? i_reg_req.wdata[PLL_EN_BIT] : en_q);
  always_ff @(posedge i_clk) single_q <= mode_wr ? i_reg_req.wdata[SINGLE_PORT_BIT] : single_q;
  always_ff @(posedge i_clk) if_q <= mode_wr ? i_reg_req.wdata[INTERP_LSB +: 2] : if_q;
  always_ff @(posedge i_clk) ok_q <= !i_reset && !mode_wr && (dat || ok_q);
  always_ff @(posedge i_clk) cnt_q <= dat ? 4'(samp) : cnt_q + 4'(samp);
  always_ff @(posedge i_clk) wait_q <= (i_reset || pll_wr || !en_q || o_pll_lock) ? 0 : wait_q + 1;
  // ====
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Pin edge needs two sync flops and the edge detect before the sample flop fires
  sequence ref_seen;
    ##3 samp;
  endsequence
  chk_read_answer: assert property (i_reg_req.rd |=> o_reg_rvalid)
    else $error("read unanswered");
  chk_bypass_no_vco: assert property (!en_q && !$past(en_q, 3) |-> !o_vco_tick)
    else $error("vco tick in bypass");
  chk_bypass_sample: assert property (!en_q && $rose(i_reference_clock_input) |-> ref_seen)
    else $error("bypass sample missing");
  chk_data_after_sample: assert property (dat |-> $past(samp))
    else $error("data pulse without sample");
  chk_data_divisor: assert property (dat && ok_q |-> cnt_q == div)
    else $error("data divisor wrong");
  chk_pll_sample_vco: assert property (en_q && samp |-> $past(o_vco_tick))
    else $error("pll sample not after vco tick");
  chk_write_unlocks: assert property (pll_wr |=> !o_pll_lock)
    else $error("lock held over write");
  chk_lock_in_time: assert property (wait_q <= LOCK_WAIT + 1)
    else $error("lock late");
endmodule : dac_sample_clock_select_multiplier_props

bind dac_sample_clock_select_multiplier dac_sample_clock_select_multiplier_props #(
  .LOCK_WAIT(LOCK_WAIT)) i_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_reference_clock_input(i_reference_clock_input), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_converter_sample_clock(o_converter_sample_clock), .o_vco_tick(o_vco_tick),
  .o_data_rate_clock_output(o_data_rate_clock_output), .o_pll_lock(o_pll_lock));

// file: tb/dac_sample_clock_select_multiplier_bench.sv
`timescale 1ns/1ps
module dac_sample_clock_select_multiplier_bench;
  import clk_sel_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        ref_run = 1'b0;
  logic        ref_pin, rvalid, samp, vco, dat, lock;
  logic [31:0] rdata, v;
  reg_req_s    req = '0;
  int          failures, tests_run, n_s, n_v, n_d, dv;
  dac_sample_clock_select_multiplier #(.LOCK_WAIT(20)) i_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_reference_clock_input(ref_pin), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_converter_sample_clock(samp), .o_vco_tick(vco),
    .o_data_rate_clock_output(dat), .o_pll_lock(lock));
  ref_clock_source i_ref (.i_clk(i_clk), .i_run(ref_run), .o_ref(ref_pin));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk) req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge i_clk) req <= '0;
    #1 d = (rvalid === 1'b1) ? rdata : 'x;
  endtask : rd
  // Window starts on a reference edge so the multiplied tick pattern lines up
  task automatic win(input int cyc);
    {n_s, n_v, n_d} = '0;
    @(posedge ref_pin);
    repeat (cyc) begin
      @(posedge i_clk) #1;
      n_s += int'(samp === 1'b1);
      n_v += int'(vco === 1'b1);
      n_d += int'(dat === 1'b1);
    end
  endtask : win
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #1_000_000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(MODE_CFG_ADDR, v);
    chk(v, MODE_CFG_RESET);
    rd(PLL_CFG_ADDR, v);
    chk(v, PLL_CFG_RESET);
    rd(8'h02, v);
    chk(v, 32'h0);
    @(posedge i_clk) ref_run <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(MODE_CFG_ADDR, {24'h0, k[1:0], 5'h0, k[2]});
      dv = ((1 << k[1:0]) >> k[2]) | int'(k[1:0] == 2'h0);
      repeat (2) win(384);
      chk(n_s, 16);
      chk(n_v, 0);
      chk(n_d, 16 / dv);
    end
    @(posedge i_clk) ref_run <= 1'b0;
    repeat (30) @(posedge i_clk);
    wr(PLL_CFG_ADDR, 32'h000f_b3ff);
    ref_run <= 1'b1;
    repeat (40) begin
      rd(PLL_CFG_ADDR, v);
      if (v[LOCK_BIT] === 1'b1) break;
    end
    chk(32'(v[LOCK_BIT]), 32'h1);
    chk(32'(v[BAND_LSB +: 6]), 32'(AUTO_BAND_DEFAULT));
    chk(32'(lock), 32'h1);
    repeat (2) win(384);
    chk(n_v, 128);
    chk(n_s, 64);
    chk(n_d, 16);
    // Fixed band 5 with divider ratio 1 and multiplier ratio 8: same oscillator rate
    wr(PLL_CFG_ADDR, 32'h000f_9b17);
    rd(PLL_CFG_ADDR, v);
    chk(32'(v[BAND_LSB +: 6]), 32'h5);
    repeat (2) win(384);
    chk(n_v, 128);
    chk(n_s, 128);
    chk(n_d, 32);
    @(posedge i_clk) ref_run <= 1'b0;
    repeat (30) @(posedge i_clk);
    wr(PLL_CFG_ADDR, PLL_CFG_RESET);
    rd(PLL_CFG_ADDR, v);
    chk(v, PLL_CFG_RESET);
    report_and_stop();
  end
endmodule : dac_sample_clock_select_multiplier_bench
